// ### pkg/wake_flag_pkg.sv
package wake_flag_pkg;

    // =========================================================
    // geometry
    localparam int PIN_COUNT  = 16;
    localparam int FLAG_WIDTH = 8;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;

    // =========================================================
    // register indices; byte address is four times the index
    localparam logic [ADDR_WIDTH-1:0] IDX_FLAGS_LOW  = 8'h05;
    localparam logic [ADDR_WIDTH-1:0] IDX_FLAGS_HIGH = 8'h06;
    localparam logic [ADDR_WIDTH-1:0] IDX_IRQ_MASK   = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] IDX_EDGE_SEL   = 8'h09;
    localparam logic [ADDR_WIDTH-1:0] IDX_MODE_STAT  = 8'h0a;

    localparam logic [ADDR_WIDTH-1:0] ADDR_FLAGS_LOW  = IDX_FLAGS_LOW << 2;
    localparam logic [ADDR_WIDTH-1:0] ADDR_FLAGS_HIGH = IDX_FLAGS_HIGH << 2;
    localparam logic [ADDR_WIDTH-1:0] ADDR_IRQ_MASK   = IDX_IRQ_MASK << 2;
    localparam logic [ADDR_WIDTH-1:0] ADDR_EDGE_SEL   = IDX_EDGE_SEL << 2;
    localparam logic [ADDR_WIDTH-1:0] ADDR_MODE_STAT  = IDX_MODE_STAT << 2;

    // =========================================================
    // reset values
    localparam logic [FLAG_WIDTH-1:0] FLAGS_RESET    = 8'h00;
    localparam logic [PIN_COUNT-1:0]  MASK_RESET     = 16'h0000;
    localparam logic [2*PIN_COUNT-1:0] EDGE_SEL_RESET = 32'h0000_0000;

    // =========================================================
    // mode status field positions
    localparam int MODE_SHALLOW_BIT = 0;
    localparam int MODE_DEEP_BIT    = 1;

    // =========================================================
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // =========================================================
    // edge select encoding of each pin's 2-bit field
    typedef enum logic [1:0] {
        EDGE_OFF     = 2'h0,
        EDGE_RISING  = 2'h1,
        EDGE_FALLING = 2'h2,
        EDGE_ANY     = 2'h3
    } pin_wake_edge_select_t;

    // =========================================================
    // software-owned configuration
    typedef struct packed {
        logic [2*PIN_COUNT-1:0] edge_sel;
        logic [PIN_COUNT-1:0]   irq_mask;
    } wake_cfg_t;

    // one held write: address and data may arrive in either order
    typedef struct packed {
        logic                    addr_held;
        logic                    data_held;
        logic [ADDR_WIDTH-1:0]   addr;
        logic [DATA_WIDTH-1:0]   data;
        logic [DATA_WIDTH/8-1:0] strb;
    } write_hold_t;

endpackage

// ### rtl/low_leak_wake_unit.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Overview of operation
// - enabled pin's detected wake edge during stop sets its flag to 1.
// - flags are readable and write-1-to-clear; writing 1 clears, writing 0 leaves unchanged.
// - clearing a pin's edge select never clears its already set flag.
// - in shallow stop a set flag raises the cpu interrupt wake request.
// - in deep stop a set flag raises the chip reset wake request.
// - flags clear only on chip reset not from deep-stop wakeup.
// - high flag register at index 6h; bit 7 is pin 15, bit 0 pin 8.
// - low flag register bit n maps to wake pin n.
// - edge select 00 off, 01 rising, 10 falling, 11 any change.
module low_leak_wake_unit #(
    parameter int PIN_COUNT = wake_flag_pkg::PIN_COUNT
) (
    input  wire logic                                  aclk,
    input  wire logic                                  aresetn,
    input  wire logic                                  wake_reset_n,
    input  wire logic [PIN_COUNT-1:0]                  wake_pin_input,
    input  wire logic                                  low_leak_stop_mode,
    input  wire logic                                  very_low_leak_stop_mode,
    output logic                                       wake_cpu_interrupt,
    output logic                                       wake_reset_request,
    output logic                                       irq,
    input  wire logic [wake_flag_pkg::ADDR_WIDTH-1:0]  s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output logic                                       s_axi_awready,
    input  wire logic [wake_flag_pkg::DATA_WIDTH-1:0]  s_axi_wdata,
    input  wire logic [wake_flag_pkg::DATA_WIDTH/8-1:0] s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output logic                                       s_axi_wready,
    output logic [1:0]                                 s_axi_bresp,
    output logic                                       s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    input  wire logic [wake_flag_pkg::ADDR_WIDTH-1:0]  s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output logic                                       s_axi_arready,
    output logic [wake_flag_pkg::DATA_WIDTH-1:0]       s_axi_rdata,
    output logic [1:0]                                 s_axi_rresp,
    output logic                                       s_axi_rvalid,
    input  wire logic                                  s_axi_rready
);

    localparam int FW = wake_flag_pkg::FLAG_WIDTH;
    localparam int DW = wake_flag_pkg::DATA_WIDTH;

    // =========================================================
    // pin synchronisers and edge detection
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] pin_prev;
    logic [PIN_COUNT-1:0] pin_event;
    logic                 in_stop;

    wake_flag_pkg::wake_cfg_t cfg;
    wake_flag_pkg::wake_cfg_t next_cfg;

    // no reset on the chain: it only follows the pins, and reset outlasts the
    // three stages, so no false edge is seen when reset ends
    // pin_meta is read only by pin_sync
    always_ff @(posedge aclk) begin
        pin_meta <= wake_pin_input;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end

    assign in_stop = low_leak_stop_mode | very_low_leak_stop_mode;

    // pulses shorter than a clock period may be missed; the pins are assumed slow
    generate
        for (genvar p = 0; p < PIN_COUNT; p++) begin : g_detect
            wake_flag_pkg::pin_wake_edge_select_t sel;
            assign sel = wake_flag_pkg::pin_wake_edge_select_t'(cfg.edge_sel[2*p +: 2]);
            always_comb begin
                unique case (sel)
                    wake_flag_pkg::EDGE_OFF:     pin_event[p] = 1'b0;
                    wake_flag_pkg::EDGE_RISING:  pin_event[p] = pin_sync[p] & ~pin_prev[p];
                    wake_flag_pkg::EDGE_FALLING: pin_event[p] = ~pin_sync[p] & pin_prev[p];
                    wake_flag_pkg::EDGE_ANY:     pin_event[p] = pin_sync[p] ^ pin_prev[p];
                endcase
            end
        end
    endgenerate

    // =========================================================
    // axi4-lite write channel
    wake_flag_pkg::write_hold_t wr;
    wake_flag_pkg::write_hold_t next_wr;
    logic                       next_awready;
    logic                       next_wready;
    logic                       next_bvalid;
    logic [1:0]                 next_bresp;
    logic                       wr_fire;
    logic [PIN_COUNT-1:0]       flag_clear;
    logic                       addr_mapped;

    assign wr_fire = wr.addr_held & wr.data_held & ~s_axi_bvalid;

    // handshake only; what the held write does is decoded below
    always_comb begin
        next_wr      = wr;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        if (s_axi_awvalid & s_axi_awready) begin
            next_wr.addr_held = 1'b1;
            next_wr.addr      = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            next_wr.data_held = 1'b1;
            next_wr.data      = s_axi_wdata;
            next_wr.strb      = s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_wr.addr_held = 1'b0;
            next_wr.data_held = 1'b0;
            next_bvalid       = 1'b1;
            next_bresp        = addr_mapped ? wake_flag_pkg::RESP_OKAY
                                            : wake_flag_pkg::RESP_SLVERR;
        end
        next_awready = ~next_wr.addr_held & ~next_bvalid;
        next_wready  = ~next_wr.data_held & ~next_bvalid;
    end

    // register write decode; a write to an unmapped word changes nothing
    always_comb begin
        next_cfg    = cfg;
        flag_clear  = '0;
        addr_mapped = 1'b1;
        if (wr_fire) begin
            unique case (wr.addr)
                wake_flag_pkg::ADDR_FLAGS_LOW: begin
                    if (wr.strb[0]) begin
                        flag_clear[FW-1:0] = wr.data[FW-1:0];
                    end
                end
                wake_flag_pkg::ADDR_FLAGS_HIGH: begin
                    if (wr.strb[0]) begin
                        flag_clear[2*FW-1:FW] = wr.data[FW-1:0];
                    end
                end
                wake_flag_pkg::ADDR_IRQ_MASK: begin
                    for (int b = 0; b < PIN_COUNT/8; b++) begin
                        if (wr.strb[b]) begin
                            next_cfg.irq_mask[8*b +: 8] = wr.data[8*b +: 8];
                        end
                    end
                end
                wake_flag_pkg::ADDR_EDGE_SEL: begin
                    for (int b = 0; b < PIN_COUNT/4; b++) begin
                        if (wr.strb[b]) begin
                            next_cfg.edge_sel[8*b +: 8] = wr.data[8*b +: 8];
                        end
                    end
                end
                wake_flag_pkg::ADDR_MODE_STAT: begin
                    // read-only status: the write is answered but dropped
                    addr_mapped = 1'b1;
                end
                default: begin
                    addr_mapped = 1'b0;
                end
            endcase
        end
    end

    // bus-side state restarts on every reset, including deep-stop wakeup resets
    always_ff @(posedge aclk) begin
        if (!aresetn || !wake_reset_n) begin
            wr            <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= wake_flag_pkg::RESP_OKAY;
        end else begin
            wr            <= next_wr;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
        end
    end

    // =========================================================
    // wake flags and configuration
    logic [PIN_COUNT-1:0] flags;
    logic [PIN_COUNT-1:0] next_flags;

    // set wins over a simultaneous clear; edge select changes never clear
    generate
        for (genvar p = 0; p < PIN_COUNT; p++) begin : g_flag
            always_comb begin
                next_flags[p] = (flags[p] & ~flag_clear[p])
                              | (pin_event[p] & in_stop);
            end
        end
    endgenerate

    // only chip reset clears these; deep-stop wakeup resets must not lose the source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= {2{wake_flag_pkg::FLAGS_RESET}};
        end else begin
            flags <= next_flags;
        end
    end

    // configuration survives deep-stop wakeup resets as the flags do
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= '{edge_sel: wake_flag_pkg::EDGE_SEL_RESET,
                     irq_mask: wake_flag_pkg::MASK_RESET};
        end else begin
            cfg <= next_cfg;
        end
    end

    // =========================================================
    // wake requests and interrupt
    logic next_cpu_wake;
    logic next_reset_wake;
    logic next_irq;

    // registered so the request lines cannot glitch while flags and mode change
    always_comb begin
        next_cpu_wake   = low_leak_stop_mode & (|flags);
        next_reset_wake = very_low_leak_stop_mode & (|flags);
        next_irq        = |(flags & cfg.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !wake_reset_n) begin
            wake_cpu_interrupt <= 1'b0;
            wake_reset_request <= 1'b0;
            irq                <= 1'b0;
        end else begin
            wake_cpu_interrupt <= next_cpu_wake;
            wake_reset_request <= next_reset_wake;
            irq                <= next_irq;
        end
    end

    // =========================================================
    // axi4-lite read channel
    logic          next_arready;
    logic          next_rvalid;
    logic [DW-1:0] next_rdata;
    logic [1:0]    next_rresp;
    logic [DW-1:0] read_mux;
    logic          read_mapped;

    // read decode; unmapped words read as zero with an error response
    always_comb begin
        read_mux    = '0;
        read_mapped = 1'b1;
        unique case (s_axi_araddr)
            wake_flag_pkg::ADDR_FLAGS_LOW:  read_mux[FW-1:0] = flags[FW-1:0];
            wake_flag_pkg::ADDR_FLAGS_HIGH: read_mux[FW-1:0] = flags[2*FW-1:FW];
            wake_flag_pkg::ADDR_IRQ_MASK:   read_mux[PIN_COUNT-1:0] = cfg.irq_mask;
            wake_flag_pkg::ADDR_EDGE_SEL:   read_mux[2*PIN_COUNT-1:0] = cfg.edge_sel;
            wake_flag_pkg::ADDR_MODE_STAT: begin
                // the stop mode inputs as they stand, not latched
                read_mux[wake_flag_pkg::MODE_SHALLOW_BIT] = low_leak_stop_mode;
                read_mux[wake_flag_pkg::MODE_DEEP_BIT]    = very_low_leak_stop_mode;
            end
            default: read_mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_rvalid & s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = read_mapped ? wake_flag_pkg::RESP_OKAY : wake_flag_pkg::RESP_SLVERR;
            next_rdata  = read_mux;
        end
        // one read in flight: refuse the next address until the data is taken
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !wake_reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= wake_flag_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

endmodule

// ### test/wake_flag_sva.sv
`timescale 1ns/1ns

// =========================================
// bus handshake and wake output checks
module wake_flag_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wake_reset_n,
    input wire logic low_leak_stop_mode,
    input wire logic very_low_leak_stop_mode,
    input wire logic wake_cpu_interrupt,
    input wire logic wake_reset_request,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    // the wakeup reset also clears the bus side, so it silences the checks too
    default disable iff (!aresetn || !wake_reset_n);

    sequence w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_done;
        s_axi_bvalid && s_axi_bready;
    endsequence

    AST_WRITE_ANSWER: assert property (w_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_B_RELEASE: assert property (b_done |=> !s_axi_bvalid)
        else $error("write response not released");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during data");
    AST_CPU_MODE: assert property (!low_leak_stop_mode |=> !wake_cpu_interrupt)
        else $error("cpu wake outside shallow stop");
    AST_RESET_MODE: assert property (!very_low_leak_stop_mode |=> !wake_reset_request)
        else $error("reset wake outside deep stop");
endmodule

bind low_leak_wake_unit wake_flag_sva wake_flag_sva_i (
    .aclk, .aresetn, .wake_reset_n, .low_leak_stop_mode, .very_low_leak_stop_mode,
    .wake_cpu_interrupt, .wake_reset_request, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

// ### test/bus_master_model.sv
`timescale 1ns/1ns

// =========================================
// software side: one write or read at a time
module bus_master_model (
    input  wire logic        aclk,
    output logic      [7:0]  s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic      [31:0] s_axi_wdata,
    output logic      [3:0]  s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic      [7:0]  s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // response readies stay high so no ready is ever re-raised in one step
    initial begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
    end

    // ready is looked at mid-cycle; it is stable there up to the taking edge
    task automatic write_word(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic ta, tw, b;
        b = 1'b0;
        r = 2'bxx;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~v;
            end
        end
        if (!b) test_low_leak_wake_unit.hang();
    endtask

    task automatic read_word(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ta, b;
        b = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end
        if (!b) test_low_leak_wake_unit.hang();
    endtask
endmodule

// ### test/test_low_leak_wake_unit.sv
`timescale 1ns/1ns

module test_low_leak_wake_unit;
    logic        aclk, aresetn, wake_reset_n, low_leak_stop_mode, very_low_leak_stop_mode;
    logic        wake_cpu_interrupt, wake_reset_request, irq;
    logic [15:0] wake_pin_input, flags_m, mask_m, pins_m;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, sel_m, rnd, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          fails, comparisons;

    low_leak_wake_unit low_leak_wake_unit_i (.aclk, .aresetn, .wake_reset_n, .wake_pin_input,
        .low_leak_stop_mode, .very_low_leak_stop_mode, .wake_cpu_interrupt, .wake_reset_request,
        .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    bus_master_model bus_master_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    always #4 aclk = ~aclk;

    // =========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic hang();
        fails++;
        complete_run();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        bus_master_model_i.write_word(a, v, r);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        bus_master_model_i.read_word(a, d, r);
        check(d, ev);
        check({30'h0, r}, {30'h0, er});
    endtask

    // edge select bit 0 picks rising, bit 1 falling; a stop mode is always on here
    task automatic pins(input logic [15:0] p);
        logic [1:0] e;
        for (int i = 0; i < 16; i++) begin
            e = sel_m[2*i +: 2];
            if ((e[0] && !pins_m[i] && p[i]) || (e[1] && pins_m[i] && !p[i]))
                flags_m[i] = 1'b1;
        end
        wake_pin_input <= p;
        repeat (6) @(posedge aclk);
        pins_m = p;
    endtask

    task automatic pulse_reset(input logic chip);
        if (chip)
            aresetn <= 1'b0;
        else
            wake_reset_n <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wake_reset_n <= 1'b1;
        @(posedge aclk);
    endtask

    // =========================================
    // main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        wake_reset_n = 1'b1;
        low_leak_stop_mode = 1'b0;
        very_low_leak_stop_mode = 1'b0;
        wake_pin_input = 16'h0000;
        {flags_m, mask_m, pins_m, sel_m} = 80'h0;
        fails = 0;
        comparisons = 0;
        rnd = 32'd83769;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(wake_flag_pkg::ADDR_FLAGS_LOW, 32'h0, wake_flag_pkg::RESP_OKAY);
        rd(wake_flag_pkg::ADDR_FLAGS_HIGH, 32'h0, wake_flag_pkg::RESP_OKAY);
        rd(8'h00, 32'h0, wake_flag_pkg::RESP_SLVERR);
        wr(8'h00, 32'hffff_ffff, wake_flag_pkg::RESP_SLVERR);
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            mask_m = rnd[15:0];
            rnd = lfsr(rnd);
            sel_m = (k == 0) ? 32'he4e4_e4e4 : rnd;
            wr(wake_flag_pkg::ADDR_EDGE_SEL, sel_m, wake_flag_pkg::RESP_OKAY);
            wr(wake_flag_pkg::ADDR_IRQ_MASK, {16'h0, mask_m}, wake_flag_pkg::RESP_OKAY);
            low_leak_stop_mode <= (k == 0);
            very_low_leak_stop_mode <= (k == 1);
            for (int j = 0; j < 6; j++) begin
                rnd = lfsr(rnd);
                pins(rnd[15:0]);
            end
            check({31'h0, wake_cpu_interrupt}, {31'h0, k == 0 && |flags_m});
            check({31'h0, wake_reset_request}, {31'h0, k == 1 && |flags_m});
            wr(wake_flag_pkg::ADDR_MODE_STAT, 32'hffff_ffff, wake_flag_pkg::RESP_OKAY);
            rd(wake_flag_pkg::ADDR_MODE_STAT, {30'h0, k == 1, k == 0}, 2'h0);
            check({31'h0, irq}, {31'h0, |(flags_m & mask_m)});
            sel_m = 32'h0;
            wr(wake_flag_pkg::ADDR_EDGE_SEL, sel_m, wake_flag_pkg::RESP_OKAY);
            rd(wake_flag_pkg::ADDR_FLAGS_LOW, {24'h0, flags_m[7:0]}, 2'h0);
            rd(wake_flag_pkg::ADDR_FLAGS_HIGH, {24'h0, flags_m[15:8]}, 2'h0);
            rnd = lfsr(rnd);
            wr(wake_flag_pkg::ADDR_FLAGS_LOW, rnd, wake_flag_pkg::RESP_OKAY);
            wr(wake_flag_pkg::ADDR_FLAGS_HIGH, rnd >> 8, wake_flag_pkg::RESP_OKAY);
            flags_m = flags_m & ~rnd[15:0];
            rd(wake_flag_pkg::ADDR_FLAGS_LOW, {24'h0, flags_m[7:0]}, 2'h0);
            rd(wake_flag_pkg::ADDR_FLAGS_HIGH, {24'h0, flags_m[15:8]}, 2'h0);
            check({31'h0, irq}, {31'h0, |(flags_m & mask_m)});
        end
        sel_m = 32'hffff_ffff;
        wr(wake_flag_pkg::ADDR_EDGE_SEL, sel_m, wake_flag_pkg::RESP_OKAY);
        pins(~pins_m);
        // the edge of pin 0 reaches its flag at the same edge as the clear of it
        wake_pin_input <= ~pins_m;
        pins_m = ~pins_m;
        @(posedge aclk);
        wr(wake_flag_pkg::ADDR_FLAGS_LOW, 32'h1, wake_flag_pkg::RESP_OKAY);
        rd(wake_flag_pkg::ADDR_FLAGS_LOW, {24'h0, flags_m[7:0]}, 2'h0);
        pulse_reset(1'b0);
        rd(wake_flag_pkg::ADDR_FLAGS_HIGH, {24'h0, flags_m[15:8]}, 2'h0);
        rd(wake_flag_pkg::ADDR_IRQ_MASK, {16'h0, mask_m}, 2'h0);
        pulse_reset(1'b1);
        rd(wake_flag_pkg::ADDR_FLAGS_LOW, 32'h0, wake_flag_pkg::RESP_OKAY);
        rd(wake_flag_pkg::ADDR_FLAGS_HIGH, 32'h0, wake_flag_pkg::RESP_OKAY);
        complete_run();
    end
endmodule
